// ===== src/ccs_defs.svh
// Constants of the command channel selector: encodings, offsets, reset values
// Assumes inclusion by bare name from the package and the design file
// What this block does
// - Channel two takes its command from terminals, keypad, remote display, Modbus or network card.
// - Channel-two source and switching select are writable only with separate profile and level 3.
// - Switching select offers fixed channel one or channel two, and resets to channel one.
// - Switching select can follow any one of the six logic inputs.
// - Switching select can follow any one of bits 11 to 15 of the Modbus control word.
// - Switching select can follow any one of bits 11 to 15 of the network control word.
// - A followed signal at 0 makes channel one active.
// - A followed signal at 1 makes channel two active.
// - Copy goes only from channel one to channel two and resets to no copy.
// - Copy select encodes no copy, reference only, command only, or both.
`ifndef CCS_DEFS_SVH
`define CCS_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define CCS_ADDR_W 4
`define CCS_OFF_CONFIG 4'h0
`define CCS_OFF_CH2_SRC 4'h1
`define CCS_OFF_SWITCH 4'h2
`define CCS_OFF_COPY 4'h3
`define CCS_OFF_STATUS 4'h4

// ----------------------------------------------------------------
// Encodings and fields
// ----------------------------------------------------------------
`define CCS_SRC_TERMINALS 3'h0
`define CCS_SRC_KEYPAD 3'h1
`define CCS_SRC_REMOTE 3'h2
`define CCS_SRC_MODBUS 3'h3
`define CCS_SRC_NETWORK 3'h4
`define CCS_SW_CH1 5'h00
`define CCS_SW_CH2 5'h01
`define CCS_SW_LI_BASE 5'h02
`define CCS_SW_LI_LAST 5'h07
`define CCS_SW_MB_BASE 5'h08
`define CCS_SW_MB_LAST 5'h0C
`define CCS_SW_NET_BASE 5'h0D
`define CCS_SW_NET_LAST 5'h11
`define CCS_WORD_BIT_LO 4'hB
`define CCS_COPY_NONE 2'h0
`define CCS_COPY_REF 2'h1
`define CCS_COPY_CMD 2'h2
`define CCS_COPY_ALL 2'h3
`define CCS_LEVEL_THREE 2'h3
`define CCS_CFG_SEP_BIT 2
`define CCS_RST_CH2_SRC `CCS_SRC_MODBUS
`define CCS_RST_SWITCH `CCS_SW_CH1
`define CCS_RST_COPY `CCS_COPY_NONE

`endif

// ===== src/ccs_pkg.sv
// Types of the command channel selector
// Assumes ccs_defs.svh on the include path
`include "ccs_defs.svh"
package ccs_pkg;
   typedef struct packed {
      logic [2:0] ch2_src;
      logic [4:0] switch_sel;
      logic [1:0] copy_sel;
   } ccs_cfg_type;

   typedef enum logic [1:0] {
      CCS_ACT_CH1 = 2'b01,
      CCS_ACT_CH2 = 2'b10
   } ccs_act_type;

   typedef struct packed {
      logic copy_ref;
      logic copy_cmd;
   } ccs_copy_type;
endpackage : ccs_pkg

// ===== src/ccs_selector.sv
// Command channel selector: register file, channel switch and copy request
// Assumes a single 50 MHz clock and synchronous inputs from the drive
`timescale 1ns/1ps
`include "ccs_defs.svh"
module ccs_selector #(
   parameter int NUM_LI = 6
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic [`CCS_ADDR_W-1:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   input wire logic profile_separate_i,
   input wire logic [1:0] access_level_i,
   input wire logic [NUM_LI-1:0] logic_in_i,
   input wire logic [15:0] serial_ctrl_word_i,
   input wire logic [15:0] net_ctrl_word_i,
   output logic channel_two_active_o,
   output logic [2:0] ch2_src_o,
   output ccs_pkg::ccs_copy_type copy_o
);

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   ccs_pkg::ccs_cfg_type cfg_r;
   ccs_pkg::ccs_act_type act_r;
   ccs_pkg::ccs_act_type act_nxt;
   logic unlocked;
   logic level3;
   logic sig;

   assign level3 = (access_level_i == `CCS_LEVEL_THREE);
   assign unlocked = profile_separate_i && level3;

   // Code range checks: a write of an unknown code is dropped
   function automatic logic src_ok(input logic [7:0] v);
      src_ok = (v[2:0] <= `CCS_SRC_NETWORK) && (v[7:3] == 5'h00);
   endfunction : src_ok

   function automatic logic sw_ok(input logic [7:0] v);
      sw_ok = (v[4:0] <= `CCS_SW_NET_LAST) && (v[7:5] == 3'h0);
   endfunction : sw_ok

   // One process owns the whole packed configuration word
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         cfg_r.ch2_src <= `CCS_RST_CH2_SRC;
         cfg_r.switch_sel <= `CCS_RST_SWITCH;
         cfg_r.copy_sel <= `CCS_RST_COPY;
      end else if (wr_i) begin
         if (unlocked && addr_i == `CCS_OFF_CH2_SRC && src_ok(wdata_i)) begin
            cfg_r.ch2_src <= wdata_i[2:0];
         end
         if (unlocked && addr_i == `CCS_OFF_SWITCH && sw_ok(wdata_i)) begin
            cfg_r.switch_sel <= wdata_i[4:0];
         end
         if (level3 && addr_i == `CCS_OFF_COPY) begin
            cfg_r.copy_sel <= wdata_i[1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Channel switching
   // ----------------------------------------------------------------
   always_comb begin
      sig = 1'b0;
      if (cfg_r.switch_sel == `CCS_SW_CH2) begin
         sig = 1'b1;
      end else if (cfg_r.switch_sel >= `CCS_SW_LI_BASE && cfg_r.switch_sel <= `CCS_SW_LI_LAST) begin
         sig = logic_in_i[3'(cfg_r.switch_sel - `CCS_SW_LI_BASE)];
      end else if (cfg_r.switch_sel >= `CCS_SW_MB_BASE && cfg_r.switch_sel <= `CCS_SW_MB_LAST) begin
         sig = serial_ctrl_word_i[4'(cfg_r.switch_sel - `CCS_SW_MB_BASE) + `CCS_WORD_BIT_LO];
      end else if (cfg_r.switch_sel >= `CCS_SW_NET_BASE
                   && cfg_r.switch_sel <= `CCS_SW_NET_LAST) begin
         sig = net_ctrl_word_i[4'(cfg_r.switch_sel - `CCS_SW_NET_BASE) + `CCS_WORD_BIT_LO];
      end
      act_nxt = sig ? ccs_pkg::CCS_ACT_CH2 : ccs_pkg::CCS_ACT_CH1;
   end

   // Registered choice keeps decode glitches off the routed command
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         act_r <= ccs_pkg::CCS_ACT_CH1;
      end else begin
         case (act_nxt)
            ccs_pkg::CCS_ACT_CH1: act_r <= ccs_pkg::CCS_ACT_CH1;
            ccs_pkg::CCS_ACT_CH2: act_r <= ccs_pkg::CCS_ACT_CH2;
            default: act_r <= ccs_pkg::CCS_ACT_CH1;
         endcase
      end
   end

   assign channel_two_active_o = (act_r == ccs_pkg::CCS_ACT_CH2);
   assign ch2_src_o = cfg_r.ch2_src;
   // Copy flows channel one to channel two only; command copy skipped when ch2 is terminals
   assign copy_o.copy_ref = cfg_r.copy_sel[0];
   assign copy_o.copy_cmd = cfg_r.copy_sel[1] && (cfg_r.ch2_src != `CCS_SRC_TERMINALS);

   // ----------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         rdata_o <= 8'h00;
      end else if (rd_i) begin
         // Read data stand for one cycle only, zero otherwise
         case (addr_i)
            `CCS_OFF_CONFIG: rdata_o <= {5'h00, unlocked, access_level_i};
            `CCS_OFF_CH2_SRC: rdata_o <= {5'h00, cfg_r.ch2_src};
            `CCS_OFF_SWITCH: rdata_o <= {3'h0, cfg_r.switch_sel};
            `CCS_OFF_COPY: rdata_o <= {6'h00, cfg_r.copy_sel};
            `CCS_OFF_STATUS: rdata_o <= {7'h00, act_r == ccs_pkg::CCS_ACT_CH2};
            default: rdata_o <= 8'h00;
         endcase
      end else begin
         rdata_o <= 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence ch1_fixed_s;
      cfg_r.switch_sel == `CCS_SW_CH1;
   endsequence

   sequence ch2_fixed_s;
      cfg_r.switch_sel == `CCS_SW_CH2;
   endsequence

   // A write that the profile or the access level must refuse
   sequence locked_wr_s;
      wr_i && !unlocked;
   endsequence

   lock_guard_a: assert property (@(posedge clk_i) disable iff (srst_i)
      locked_wr_s |=> $stable(cfg_r.switch_sel) && $stable(cfg_r.ch2_src))
      else $error("config changed while locked");
   fixed_ch1_a: assert property (@(posedge clk_i) disable iff (srst_i)
      ch1_fixed_s ##1 ch1_fixed_s |-> !channel_two_active_o)
      else $error("channel two active under fixed channel one");
   fixed_ch2_a: assert property (@(posedge clk_i) disable iff (srst_i)
      ch2_fixed_s ##1 ch2_fixed_s |-> channel_two_active_o)
      else $error("channel one active under fixed channel two");
   li_follow_a: assert property (@(posedge clk_i) disable iff (srst_i)
      (cfg_r.switch_sel == `CCS_SW_LI_BASE + 5'h2)
         |=> channel_two_active_o == $past(logic_in_i[2]))
      else $error("logic input not followed");
   mb_follow_a: assert property (@(posedge clk_i) disable iff (srst_i)
      (cfg_r.switch_sel == `CCS_SW_MB_BASE)
         |=> channel_two_active_o == $past(serial_ctrl_word_i[11]))
      else $error("serial word bit not followed");
   net_follow_a: assert property (@(posedge clk_i) disable iff (srst_i)
      (cfg_r.switch_sel == `CCS_SW_NET_LAST)
         |=> channel_two_active_o == $past(net_ctrl_word_i[15]))
      else $error("network word bit not followed");
   low_ch1_a: assert property (@(posedge clk_i) disable iff (srst_i)
      (cfg_r.switch_sel >= `CCS_SW_LI_BASE && !sig) |=> !channel_two_active_o)
      else $error("low signal not channel one");
   high_ch2_a: assert property (@(posedge clk_i) disable iff (srst_i)
      (cfg_r.switch_sel >= `CCS_SW_LI_BASE && sig) |=> channel_two_active_o)
      else $error("high signal not channel two");
   copy_reset_a: assert property (@(posedge clk_i)
      srst_i |=> cfg_r.copy_sel == `CCS_COPY_NONE && !channel_two_active_o)
      else $error("reset defaults wrong");
   copy_code_a: assert property (@(posedge clk_i) disable iff (srst_i)
      (cfg_r.copy_sel == `CCS_COPY_ALL) |-> copy_o.copy_ref)
      else $error("copy both lost reference");
   switch_reg_a: assert property (@(posedge clk_i) disable iff (srst_i)
      $rose(sig) |-> !channel_two_active_o ##1 channel_two_active_o)
      else $error("switch not registered");
   switch_fall_a: assert property (@(posedge clk_i) disable iff (srst_i)
      $fell(sig) |-> channel_two_active_o ##1 !channel_two_active_o)
      else $error("switch back not registered");
   li_first_a: assert property (@(posedge clk_i) disable iff (srst_i)
      (cfg_r.switch_sel == `CCS_SW_LI_BASE)
         |=> channel_two_active_o == $past(logic_in_i[0]))
      else $error("first logic input not followed");
   li_last_a: assert property (@(posedge clk_i) disable iff (srst_i)
      (cfg_r.switch_sel == `CCS_SW_LI_LAST)
         |=> channel_two_active_o == $past(logic_in_i[NUM_LI-1]))
      else $error("last logic input not followed");
   mb_mid_a: assert property (@(posedge clk_i) disable iff (srst_i)
      (cfg_r.switch_sel == `CCS_SW_MB_BASE + 5'h2)
         |=> channel_two_active_o == $past(serial_ctrl_word_i[13]))
      else $error("serial word middle bit not followed");
   mb_last_a: assert property (@(posedge clk_i) disable iff (srst_i)
      (cfg_r.switch_sel == `CCS_SW_MB_LAST)
         |=> channel_two_active_o == $past(serial_ctrl_word_i[15]))
      else $error("serial word top bit not followed");
   net_first_a: assert property (@(posedge clk_i) disable iff (srst_i)
      (cfg_r.switch_sel == `CCS_SW_NET_BASE)
         |=> channel_two_active_o == $past(net_ctrl_word_i[11]))
      else $error("network word low bit not followed");
   net_mid_a: assert property (@(posedge clk_i) disable iff (srst_i)
      (cfg_r.switch_sel == `CCS_SW_NET_BASE + 5'h2)
         |=> channel_two_active_o == $past(net_ctrl_word_i[13]))
      else $error("network word middle bit not followed");

   // ----------------------------------------------------------------
   // Checks: configuration writes and copy requests
   // ----------------------------------------------------------------
   src_write_a: assert property (@(posedge clk_i) disable iff (srst_i)
      (wr_i && unlocked && addr_i == `CCS_OFF_CH2_SRC && wdata_i <= {5'h00, `CCS_SRC_NETWORK})
         |=> ch2_src_o == $past(wdata_i[2:0]))
      else $error("channel two source write lost");
   src_refuse_a: assert property (@(posedge clk_i) disable iff (srst_i)
      (wr_i && addr_i == `CCS_OFF_CH2_SRC && wdata_i > {5'h00, `CCS_SRC_NETWORK})
         |=> $stable(ch2_src_o))
      else $error("unknown source code taken");
   sw_write_a: assert property (@(posedge clk_i) disable iff (srst_i)
      (wr_i && unlocked && addr_i == `CCS_OFF_SWITCH && wdata_i <= {3'h0, `CCS_SW_NET_LAST})
         |=> cfg_r.switch_sel == $past(wdata_i[4:0]))
      else $error("switch select write lost");
   sw_refuse_a: assert property (@(posedge clk_i) disable iff (srst_i)
      (wr_i && addr_i == `CCS_OFF_SWITCH && wdata_i > {3'h0, `CCS_SW_NET_LAST})
         |=> $stable(cfg_r.switch_sel))
      else $error("unknown switch code taken");
   copy_lock_a: assert property (@(posedge clk_i) disable iff (srst_i)
      (wr_i && !level3) |=> $stable(cfg_r.copy_sel))
      else $error("copy select changed below level three");
   copy_write_a: assert property (@(posedge clk_i) disable iff (srst_i)
      (wr_i && level3 && addr_i == `CCS_OFF_COPY)
         |=> cfg_r.copy_sel == $past(wdata_i[1:0]))
      else $error("copy select write lost");
   copy_term_a: assert property (@(posedge clk_i) disable iff (srst_i)
      (cfg_r.ch2_src == `CCS_SRC_TERMINALS) |-> !copy_o.copy_cmd)
      else $error("command copied onto terminal channel");
   copy_ref_a: assert property (@(posedge clk_i) disable iff (srst_i)
      copy_o.copy_ref == (cfg_r.copy_sel == `CCS_COPY_REF
                          || cfg_r.copy_sel == `CCS_COPY_ALL))
      else $error("reference copy request wrong");
   copy_cmd_a: assert property (@(posedge clk_i) disable iff (srst_i)
      (cfg_r.ch2_src != `CCS_SRC_TERMINALS)
         |-> copy_o.copy_cmd == (cfg_r.copy_sel == `CCS_COPY_CMD
                                 || cfg_r.copy_sel == `CCS_COPY_ALL))
      else $error("command copy request wrong");

endmodule : ccs_selector

// ===== sim/ccs_src_model.sv
// Model of the drive's command sources: profile, access level, inputs, control words
// Assumes the bench calls its tasks right after a rising clock edge
`timescale 1ns/1ps
module ccs_src_model (
   output logic profile_separate_o,
   output logic [1:0] access_level_o,
   output logic [5:0] logic_in_o,
   output logic [15:0] serial_ctrl_word_o,
   output logic [15:0] net_ctrl_word_o
);
   initial begin
      profile_separate_o = 1'b0;
      access_level_o = 2'h0;
      logic_in_o = 6'h2A;
      serial_ctrl_word_o = 16'hA5A5;
      net_ctrl_word_o = 16'h5A5A;
   end

   task automatic set_access(input logic profile_separate, input logic [1:0] lvl);
      profile_separate_o <= profile_separate;
      access_level_o <= lvl;
   endtask : set_access

   // Chosen line at val, every other line of the group at the inverse
   task automatic drive_line(input logic [1:0] grp, input logic [3:0] idx, input logic val);
      logic [15:0] w;
      w = val ? (16'h0001 << idx) : ~(16'h0001 << idx);
      case (grp)
         2'h0: logic_in_o <= w[5:0];
         2'h1: serial_ctrl_word_o <= w;
         default: net_ctrl_word_o <= w;
      endcase
   endtask : drive_line
endmodule : ccs_src_model

// ===== sim/tb_top.sv
// Self-checking bench of the command channel selector
// Assumes ccs_pkg and ccs_selector compiled before it
`timescale 1ns/1ps
module tb_top;
   logic clk_i, srst_i, wr_i, rd_i, profile_separate, two;
   logic [3:0] addr_i;
   logic [7:0] wdata_i, rdata_o;
   logic [1:0] lvl;
   logic [5:0] li;
   logic [15:0] sw, nw;
   logic [2:0] src;
   ccs_pkg::ccs_copy_type copy_o;
   int miscompares = 0;
   int checks_done = 0;

   ccs_src_model src_m (.profile_separate_o(profile_separate), .access_level_o(lvl), .logic_in_o(li),
      .serial_ctrl_word_o(sw), .net_ctrl_word_o(nw));
   ccs_selector #(.NUM_LI(6)) uut (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .profile_separate_i(profile_separate), .access_level_i(lvl), .logic_in_i(li),
      .serial_ctrl_word_i(sw), .net_ctrl_word_i(nw), .channel_two_active_o(two),
      .ch2_src_o(src), .copy_o(copy_o));

   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         miscompares++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask : chk

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i);
      wr_i <= 1'b1; addr_i <= a; wdata_i <= d;
      @(posedge clk_i);
      wr_i <= 1'b0;
      @(posedge clk_i);
      #1;
   endtask : wr

   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk_i);
      rd_i <= 1'b1; addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 chk("rdata", e, rdata_o);
      @(posedge clk_i);
      #1 chk("rdata_idle", 8'h00, rdata_o);
   endtask : rd

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      #1 chk("ch2_src", 8'h03, {5'h00, src});
      rd(4'h4, 8'h00);
      chk("copy", 8'h00, {6'h00, copy_o});
   endtask : t_reset

   task automatic t_lock();
      src_m.set_access(1'b0, 2'h3);
      wr(4'h2, 8'h01);
      chk("locked_prof", 8'h00, {7'h00, two});
      src_m.set_access(1'b1, 2'h2);
      wr(4'h2, 8'h01);
      chk("locked_lvl", 8'h00, {7'h00, two});
      src_m.set_access(1'b1, 2'h3);
      wr(4'h2, 8'h01);
      chk("fixed_ch2", 8'h01, {7'h00, two});
      rd(4'h4, 8'h01);
      wr(4'h2, 8'h00);
      chk("fixed_ch1", 8'h00, {7'h00, two});
      rd(4'hF, 8'h00);
   endtask : t_lock

   task automatic t_src();
      for (logic [3:0] s = 4'h0; s <= 4'h4; s++) begin
         wr(4'h1, {4'h0, s});
         chk("ch2_src", {4'h0, s}, {5'h00, src});
      end
   endtask : t_src

   task automatic t_follow();
      logic [1:0] g;
      logic [3:0] i;
      for (logic [4:0] c = 5'h02; c <= 5'h11; c++) begin
         g = (c < 5'h08) ? 2'h0 : (c < 5'h0D) ? 2'h1 : 2'h2;
         i = (g == 2'h1) ? 4'(c + 5'h03) : 4'(c - 5'h02);
         wr(4'h2, {3'h0, c});
         for (int v = 0; v < 2; v++) begin
            @(posedge clk_i);
            src_m.drive_line(g, i, v[0]);
            #1 if (v == 1) chk("follow_hold", 8'h00, {7'h00, two});
            @(posedge clk_i);
            #1 chk("follow", {7'h00, v[0]}, {7'h00, two});
         end
      end
   endtask : t_follow

   task automatic t_copy();
      wr(4'h1, 8'h01);
      for (logic [2:0] c = 3'h0; c <= 3'h3; c++) begin
         wr(4'h3, {5'h00, c});
         chk("copy", {6'h00, c[0], c[1]}, {6'h00, copy_o});
      end
      wr(4'h1, 8'h00);
      chk("copy_term", 8'h02, {6'h00, copy_o});
   endtask : t_copy

   task automatic t_refuse();
      wr(4'h1, 8'h05);
      rd(4'h1, 8'h00);
      wr(4'h2, 8'h12);
      rd(4'h2, 8'h11);
      rd(4'h3, 8'h03);
      rd(4'h0, 8'h07);
      src_m.set_access(1'b1, 2'h2);
      wr(4'h1, 8'h02);
      wr(4'h3, 8'h00);
      rd(4'h1, 8'h00);
      rd(4'h3, 8'h03);
      rd(4'h0, 8'h02);
      src_m.set_access(1'b0, 2'h3);
      wr(4'h1, 8'h02);
      wr(4'h3, 8'h00);
      rd(4'h1, 8'h00);
      chk("copy_open", 8'h00, {6'h00, copy_o});
   endtask : t_refuse

   task automatic wrap_up();
      if (miscompares == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : wrap_up

   initial begin
      srst_i = 1'b1; wr_i = 1'b0; rd_i = 1'b0; addr_i = 4'h0; wdata_i = 8'h00;
      repeat (6) @(posedge clk_i);
      srst_i <= 1'b0;
      t_reset();
      t_lock();
      t_src();
      t_follow();
      t_copy();
      t_refuse();
      wrap_up();
   end
endmodule : tb_top
